// ==== design/spipf_pkg.sv ====
// spipf_pkg: constants for the spi protocol and failsafe block.
// assumes a 24-bit frame slave clocked by a fast device clock.
package spipf_pkg;
	// ---------------------------------------------------------------
	// frame format
	// ---------------------------------------------------------------
	localparam int          FRAME_BITS   = 24;
	localparam int          PAYLOAD_BITS = 8;
	localparam int          CNT_W        = 8;
	localparam logic [1:0]  OP_INFO      = 2'h3;
	localparam logic [5:0]  ADDR_TOP     = 6'h3F;
	// ---------------------------------------------------------------
	// device information map
	// ---------------------------------------------------------------
	localparam logic [5:0]  ADDR_MAKER   = 6'h00;
	localparam logic [5:0]  ADDR_FAMILY  = 6'h01;
	localparam logic [5:0]  ADDR_PART1   = 6'h02;
	localparam logic [5:0]  ADDR_PART8   = 6'h09;
	localparam logic [5:0]  ADDR_REV     = 6'h0A;
	localparam logic [5:0]  ADDR_IFDESC  = 6'h10;
	localparam logic [5:0]  ADDR_PHASE   = 6'h20;
	localparam logic [5:0]  ADDR_GSBOPT  = 6'h3E;
	localparam logic        BURST_CAP    = 1'b1;
	localparam logic [2:0]  LEN_CODE_24  = 3'h2;
	localparam logic [1:0]  CHK_PARITY   = 2'h1;
	localparam logic [7:0]  PHASE_PATTERN = 8'h55;
	// unused status bits 20 and 16 (byte bits 4 and 0)
	localparam logic [7:0]  GSB_UNUSED   = 8'h11;
	localparam int          GSB_ERR_BIT  = 5;
	localparam int          GSB_RST_BIT  = 6;
	localparam int          GSB_NOT_BIT  = 7;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int          CS_TIMEOUT_CYC = 100000;
endpackage

// ==== design/spipf_slave.sv ====
// spipf_slave: spi slave frame engine with failsafe checks.
// assumes chip select, sck and sdi arrive from pins asynchronous to mclk;
// sck is sampled and its edges found with mclk (mode 0, msb first).
//
// What this block does
// - info read sends status byte, one payload byte, then bytes of the following addresses.
// - interface description packs burst flag, length code, zeros, check code.
// - length code 010 reported for 24-bit frames.
// - check code 01 reported for parity.
// - one odd parity bit: over the whole frame received, over the first 24 bits sent.
// - in burst, next address data loaded after each payload length.
// - burst address wraps after top; unmapped addresses read as zero.
// - burst read supported and flagged; burst bounded by chip select timeout.
// - wrong edge count discards frame and flags error next frame.
// - info reads accept 32 plus multiples of 16 edges.
// - zero edges is no error; burst adds whole payload lengths.
// - first edge falling or last edge rising discards and flags error.
// - phase test register always reads 01010101.
// - serial output driven only while chip select low.
// - chip select timeout aborts frame, tristates output, sets no flag.
// - all-zero frame with opcode 00 is stuck-low, rejected, flagged.
// - all-ones frame with opcode 11 is stuck-high, rejected, flagged.
// - changes of status_in bits 4 to 2 during a frame are kept and reported next frame; bits 1 and 0 are not reported.
// - payload loaded after status byte carries the newer app_rdata.
// - unused status bits forced zero; options register shows them as one.
// - application opcodes reach registers; unused addresses give no error.
// - protocol error flag clears after a valid frame.
// - every non-info output frame is 24 bits: status byte, app_rdata bits 15 to 1, then the parity bit.
`timescale 1ns/1ps
module spipf_slave
	import spipf_pkg::*;
#(
	parameter int unsigned CS_TIMEOUT = CS_TIMEOUT_CYC,
	parameter logic [7:0]  MAKER_ID   = 8'hA5, // arbitrary value
	parameter logic [7:0]  FAMILY_ID  = 8'h5A, // arbitrary value
	parameter logic [7:0]  PART_ID    = 8'h3C, // arbitrary value
	parameter logic [7:0]  REVISION   = 8'h10  // arbitrary value
) (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        chip_select_low_n,
	input  wire logic        sck,
	input  wire logic        sdi,
	output logic             sdo_o,
	output logic             sdo_oe,
	input  wire logic [4:0]  status_in,
	input  wire logic [15:0] app_rdata,
	output logic [5:0]       app_addr,
	output logic [1:0]       app_opcode,
	output logic [15:0]      app_wdata,
	output logic             app_valid,
	output logic             frame_error
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [2:0]  cs_s;
		logic [2:0]  sck_s;
		logic [1:0]  sdi_s;
		logic        active;
		logic        aborted;
		logic [31:0] tmr;
		logic [CNT_W-1:0] edges;
		logic        first_fall;
		logic        last_rise;
		logic [23:0] rx;
		logic [23:0] tx;
		logic        opar;
		logic        ipar;
		logic [5:0]  baddr;
		logic        info;
		logic        err;
		logic        rst_flag;
		logic [4:0]  sticky;
		logic        sdo;
		logic        oe;
		logic [5:0]  aaddr;
		logic [1:0]  aop;
		logic [15:0] awd;
		logic        avld;
		logic        ferr;
	} spipf_state_t;

	spipf_state_t s_q;
	spipf_state_t s_d;

	// ---------------------------------------------------------------
	// device information lookup
	// ---------------------------------------------------------------
	function automatic logic [7:0] info_byte(input logic [5:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a == ADDR_MAKER)
			v = MAKER_ID;
		else if (a == ADDR_FAMILY)
			v = FAMILY_ID;
		else if (a >= ADDR_PART1 && a <= ADDR_PART8)
			v = PART_ID;
		else if (a == ADDR_REV)
			v = REVISION;
		else if (a == ADDR_IFDESC)
			v = {BURST_CAP, LEN_CODE_24, 2'h0, CHK_PARITY};
		else if (a == ADDR_PHASE)
			v = PHASE_PATTERN;
		else if (a == ADDR_GSBOPT)
			v = GSB_UNUSED;
		return v;
	endfunction

	// ---------------------------------------------------------------
	// status byte
	// ---------------------------------------------------------------
	function automatic logic [7:0] gsb(input spipf_state_t s);
		logic [7:0] g;
		g = 8'h00;
		g[GSB_RST_BIT] = s.rst_flag;
		g[GSB_ERR_BIT] = s.err;
		g[3:1]         = s.sticky[4:2];
		g              = g & ~GSB_UNUSED;
		g[GSB_NOT_BIT] = ~|g[6:0];
		return g;
	endfunction

	// ---------------------------------------------------------------
	// frame checks
	// ---------------------------------------------------------------
	function automatic logic count_ok(input logic info, input logic [CNT_W-1:0] e);
		logic ok;
		ok = 1'b0;
		if (info)
			ok = e >= CNT_W'(32) && e[3:0] == 4'h0;
		else
			ok = e == CNT_W'(2 * FRAME_BITS);
		return ok;
	endfunction

	function automatic logic stuck_frame(input logic [23:0] f);
		logic lo;
		logic hi;
		lo = f == 24'h000000;
		hi = f[23:1] == {OP_INFO, ADDR_TOP, 15'h7FFF};
		return lo || hi;
	endfunction

	function automatic logic [5:0] next_addr(input logic [5:0] a);
		logic [5:0] n;
		n = a + 6'd1;
		if (a == ADDR_TOP)
			n = 6'h00;
		return n;
	endfunction

	function automatic logic [23:0] payload_load(input spipf_state_t s, input logic [15:0] rd);
		logic [23:0] t;
		t = 24'h000000;
		if (s.info)
			t = {info_byte(s.baddr), 16'h0000};
		else
			t = {rd, 8'h00};
		return t;
	endfunction

	function automatic logic frame_bad(input spipf_state_t s);
		logic bad;
		bad = 1'b0;
		if (!count_ok(s.info, s.edges))
			bad = 1'b1;
		if (s.first_fall || s.last_rise)
			bad = 1'b1;
		if (stuck_frame(s.rx))
			bad = 1'b1;
		if (!s.ipar)
			bad = 1'b1;
		return bad;
	endfunction

	// ---------------------------------------------------------------
	// state steps
	// ---------------------------------------------------------------
	function automatic spipf_state_t on_start(input spipf_state_t q, input spipf_state_t d, input logic [4:0] st);
		spipf_state_t n;
		logic [7:0]   g;
		n = d;
		g = gsb(q);
		n.active     = 1'b1;
		n.tmr        = '0;
		n.edges      = '0;
		n.first_fall = 1'b0;
		n.last_rise  = 1'b0;
		n.info       = 1'b0;
		n.ipar       = 1'b0;
		n.tx         = {g, 16'h0000};
		n.sdo        = g[GSB_NOT_BIT];
		n.opar       = g[GSB_NOT_BIT];
		n.oe         = 1'b1;
		n.sticky     = st;
		return n;
	endfunction

	function automatic spipf_state_t on_abort(input spipf_state_t d);
		spipf_state_t n;
		n = d;
		n.active  = 1'b0;
		n.aborted = 1'b1;
		n.oe      = 1'b0;
		return n;
	endfunction

	function automatic spipf_state_t on_rise(input spipf_state_t q, input spipf_state_t d);
		spipf_state_t n;
		n = d;
		n.edges     = q.edges + 1'b1;
		n.last_rise = 1'b1;
		if (q.edges < CNT_W'(2 * FRAME_BITS))
			n.rx = {q.rx[22:0], q.sdi_s[1]};
		n.ipar = q.ipar ^ q.sdi_s[1];
		if (q.edges == CNT_W'(14) && q.rx[6:5] == OP_INFO) begin
			n.info  = 1'b1;
			n.baddr = {q.rx[4:0], q.sdi_s[1]};
		end
		return n;
	endfunction

	function automatic spipf_state_t on_fall(input spipf_state_t q, input spipf_state_t d, input logic [15:0] rd);
		spipf_state_t n;
		n = d;
		if (q.edges == '0)
			n.first_fall = 1'b1;
		n.last_rise = 1'b0;
		n.edges     = q.edges + 1'b1;
		if (q.edges == CNT_W'(15)) begin
			n.tx = payload_load(q, rd);
		end else if (q.info && q.edges > CNT_W'(15) && q.edges[3:0] == 4'hF) begin
			n.baddr = next_addr(q.baddr);
			n.tx    = {info_byte(next_addr(q.baddr)), 16'h0000};
		end else begin
			n.tx = {q.tx[22:0], 1'b0};
		end
		n.sdo = n.tx[23];
		if (q.edges == CNT_W'(45))
			n.sdo = ~q.opar;
		else if (q.edges < CNT_W'(45))
			n.opar = q.opar ^ n.tx[23];
		return n;
	endfunction

	function automatic spipf_state_t on_accept(input spipf_state_t q, input spipf_state_t d);
		spipf_state_t n;
		n = d;
		n.err      = 1'b0;
		n.rst_flag = 1'b0;
		if (!q.info) begin
			n.aaddr = q.rx[21:16];
			n.aop   = q.rx[23:22];
			n.awd   = {q.rx[15:1], 1'b0};
			n.avld  = 1'b1;
		end
		return n;
	endfunction

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic cs_low;
		logic rise;
		logic fall;
		cs_low = 1'b0;
		rise   = 1'b0;
		fall   = 1'b0;
		// -----------------------------------------------------------
		// input sampling
		// -----------------------------------------------------------
		s_d        = s_q;
		s_d.cs_s   = {s_q.cs_s[1:0], chip_select_low_n};
		s_d.sck_s  = {s_q.sck_s[1:0], sck};
		s_d.sdi_s  = {s_q.sdi_s[0], sdi};
		s_d.avld   = 1'b0;
		s_d.ferr   = 1'b0;
		s_d.sticky = s_q.sticky | status_in;
		cs_low     = ~s_q.cs_s[2];
		rise       = s_q.sck_s[2:1] == 2'b01;
		fall       = s_q.sck_s[2:1] == 2'b10;
		// -----------------------------------------------------------
		// frame sequencing
		// -----------------------------------------------------------
		if (cs_low && !s_q.active && !s_q.aborted) begin
			s_d = on_start(s_q, s_d, status_in);
		end else if (s_q.active && cs_low) begin
			s_d.tmr = s_q.tmr + 32'd1;
			if (s_q.tmr >= CS_TIMEOUT - 1) begin
				s_d = on_abort(s_d);
			end else if (rise) begin
				s_d = on_rise(s_q, s_d);
			end else if (fall) begin
				s_d = on_fall(s_q, s_d, app_rdata);
			end
		end else if (!cs_low) begin
			s_d.aborted = 1'b0;
			s_d.oe      = 1'b0;
			if (s_q.active) begin
				s_d.active = 1'b0;
				if (s_q.edges == '0) begin
					s_d.err = s_q.err; // idle select
				end else if (frame_bad(s_q)) begin
					s_d.err  = 1'b1;
					s_d.ferr = 1'b1;
				end else begin
					s_d = on_accept(s_q, s_d);
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s_q          <= '0;
			s_q.cs_s     <= 3'h7;
			s_q.rst_flag <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign sdo_o       = s_q.sdo;
	assign sdo_oe      = s_q.oe;
	assign app_addr    = s_q.aaddr;
	assign app_opcode  = s_q.aop;
	assign app_wdata   = s_q.awd;
	assign app_valid   = s_q.avld;
	assign frame_error = s_q.ferr;
endmodule

// ==== tb/spipf_slave_monitor.sv ====
// spipf_slave_monitor: port assertions for the spi slave.
// assumes binding to spipf_slave and sight of its ports only.
`timescale 1ns/1ps
module spipf_slave_monitor
	import spipf_pkg::*;
#(
	parameter int unsigned CS_TIMEOUT = CS_TIMEOUT_CYC
) (
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic        chip_select_low_n,
	input wire logic        sdo_oe,
	input wire logic [1:0]  app_opcode,
	input wire logic [15:0] app_wdata,
	input wire logic        app_valid,
	input wire logic        frame_error
);
	int unsigned low_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// ---------------------------------------------------------------
	// cycles the output has been driven
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			low_q <= 0;
		else
			low_q <= sdo_oe ? low_q + 1 : 0;
	end
	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	oe_released_a: assert property (chip_select_low_n [*8] |-> !sdo_oe)
		else $error("output driven with chip select high");
	oe_starts_a: assert property ($fell(chip_select_low_n) |-> ##[1:8] sdo_oe)
		else $error("output not driven after chip select fell");
	timeout_bound_a: assert property (low_q <= CS_TIMEOUT + 8)
		else $error("output driven past chip select timeout");
	timeout_silent_a: assert property (!chip_select_low_n && $fell(sdo_oe) |=> !frame_error [*8])
		else $error("timeout raised a flag");
	error_at_end_a: assert property (frame_error |-> chip_select_low_n && $past(chip_select_low_n))
		else $error("frame rejected before frame end");
	one_verdict_a: assert property (!(app_valid && frame_error))
		else $error("frame both accepted and rejected");
	error_pulse_a: assert property (frame_error |=> !frame_error)
		else $error("reject pulse too long");
	info_not_app_a: assert property (app_valid |-> app_opcode != OP_INFO)
		else $error("info read reached application side");
	parity_slot_a: assert property (app_valid |-> app_wdata[0] == 1'b0)
		else $error("parity position not cleared");
	cover property (app_valid);
	cover property (frame_error);
	cover property (!chip_select_low_n && $fell(sdo_oe));
endmodule
bind spipf_slave spipf_slave_monitor #(.CS_TIMEOUT(CS_TIMEOUT)) i_spipf_slave_monitor (
	.mclk(mclk), .reset_n(reset_n), .chip_select_low_n(chip_select_low_n), .sdo_oe(sdo_oe),
	.app_opcode(app_opcode), .app_wdata(app_wdata), .app_valid(app_valid), .frame_error(frame_error));

// ==== tb/spipf_host_model.sv ====
// spipf_host_model: spi master, mode 0, msb first, 80 ns sck.
// assumes a pulled-up sdo line; all changes at mclk falling edges.
`timescale 1ns/1ps
module spipf_host_model (
	input  wire logic mclk,
	output logic      chip_select_low_n,
	output logic      sck,
	output logic      sdi,
	input  wire logic sdo,
	input  wire logic sdo_oe
);
	initial begin
		chip_select_low_n = 1'b1;
		sck = 1'b0;
		sdi = 1'b0;
	end
	// n clocks of frame bits from fr[31] down, sdo sampled on each rise
	task automatic xfer(input logic [31:0] fr, input int n, output logic [31:0] rx);
		rx = '0;
		@(negedge mclk) chip_select_low_n = 1'b0;
		repeat (8) @(negedge mclk);
		for (int i = 0; i < n; i++) begin
			sdi = fr[31-i];
			repeat (4) @(negedge mclk);
			sck = 1'b1;
			rx = {rx[30:0], sdo};
			repeat (4) @(negedge mclk);
			sck = 1'b0;
		end
		repeat (8) @(negedge mclk);
		chip_select_low_n = 1'b1;
		sdi = ~sdi;
		repeat (12) @(negedge mclk);
	endtask
	// chip select low with no sck edges
	task automatic hold_low(input int cyc, output logic oe_end);
		@(negedge mclk) chip_select_low_n = 1'b0;
		repeat (cyc) @(negedge mclk);
		oe_end = sdo_oe;
		chip_select_low_n = 1'b1;
		repeat (12) @(negedge mclk);
	endtask
endmodule

// ==== tb/spipf_slave_tb_top.sv ====
// spipf_slave_tb_top: frame-level tests of the spi slave.
// assumes the host model and the bound monitor.
`timescale 1ns/1ps
module spipf_slave_tb_top
	import spipf_pkg::*;
;
	logic mclk, reset_n, cs_n, sck, sdi, sdo_o, sdo_oe, app_valid, frame_error, oe;
	logic [4:0] status_in;
	logic [15:0] app_rdata, app_wdata;
	logic [5:0] app_addr;
	logic [1:0] app_opcode;
	logic [31:0] rx;
	int mismatches, checks, errs, vals;
	wire sdo_line = sdo_oe ? sdo_o : 1'b1;
	spipf_slave #(.CS_TIMEOUT(2000)) i_spipf_slave (.mclk(mclk), .reset_n(reset_n), .chip_select_low_n(cs_n),
		.sck(sck), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .status_in(status_in), .app_rdata(app_rdata),
		.app_addr(app_addr), .app_opcode(app_opcode), .app_wdata(app_wdata), .app_valid(app_valid),
		.frame_error(frame_error));
	spipf_host_model i_spipf_host_model (.mclk(mclk), .chip_select_low_n(cs_n), .sck(sck), .sdi(sdi),
		.sdo(sdo_line), .sdo_oe(sdo_oe));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (frame_error === 1'b1) errs++;
		if (app_valid === 1'b1) vals++;
	end
	function automatic logic [31:0] fr(logic [1:0] op, logic [5:0] a, logic [15:0] d);
		return {op, a, d[15:1], ~^{op, a, d[15:1]}, 8'h00};
	endfunction
	task automatic check(logic [31:0] seen, logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#400us;
		mismatches++;
		finish_test();
	end
	initial begin
		reset_n = 1'b0;
		status_in = 5'h00;
		app_rdata = 16'h1234;
		repeat (10) @(negedge mclk);
		reset_n = 1'b1;
		repeat (8) @(negedge mclk);
		i_spipf_host_model.xfer(fr(OP_INFO, ADDR_IFDESC, 16'h0), 24, rx);
		check(rx[23:8], 16'h40A1);
		check(^rx[23:0], 1'b1);
		i_spipf_host_model.xfer(fr(OP_INFO, ADDR_PHASE, 16'h0), 24, rx);
		check(rx[23:8], 16'h8055);
		i_spipf_host_model.xfer(fr(OP_INFO, ADDR_GSBOPT, 16'h0), 32, rx);
		check(rx[31:16], 16'h8011);
		i_spipf_host_model.xfer(fr(2'h1, 6'h05, 16'hBEEF), 24, rx);
		check({app_opcode, app_addr, app_wdata, vals[7:0]}, {2'h1, 6'h05, 16'hBEEE, 8'h01});
		i_spipf_host_model.xfer(fr(2'h0, 6'h05, 16'h0), 24, rx);
		check(rx[15:8], 8'h12);
		i_spipf_host_model.xfer(fr(OP_INFO, ADDR_PHASE - 6'd1, 16'h0), 32, rx);
		check(rx[15:9], 7'h2A);
		check(rx[31:24] inside {8'h00, 8'hFF}, 1'b0);
		i_spipf_host_model.xfer(fr(OP_INFO, ADDR_PHASE, 16'h0), 23, rx);
		check(errs, 1);
		i_spipf_host_model.xfer(fr(OP_INFO, ADDR_PHASE, 16'h0), 24, rx);
		check(rx[23:8], 16'h2055);
		i_spipf_host_model.xfer(32'h0, 24, rx);
		i_spipf_host_model.xfer(32'hFFFFFF00, 24, rx);
		i_spipf_host_model.xfer(fr(OP_INFO, ADDR_PHASE, 16'h0) ^ 32'h100, 24, rx);
		check(errs, 4);
		i_spipf_host_model.xfer(fr(OP_INFO, ADDR_PHASE, 16'h0), 24, rx);
		check(rx[23:16], 8'h20);
		i_spipf_host_model.hold_low(20, oe);
		check({oe, errs[7:0]}, {1'b1, 8'h04});
		i_spipf_host_model.hold_low(2100, oe);
		check({oe, errs[7:0]}, {1'b0, 8'h04});
		@(negedge mclk) status_in = 5'h10;
		@(negedge mclk) status_in = 5'h00;
		i_spipf_host_model.xfer(fr(OP_INFO, ADDR_PHASE, 16'h0), 24, rx);
		check(rx[23:8], 16'h0855);
		i_spipf_host_model.xfer(fr(OP_INFO, ADDR_PHASE, 16'h0), 24, rx);
		check(rx[23:8], 16'h8055);
		finish_test();
	end
endmodule
